// File: rtl/sasp_pkg.sv
// Operation
// - control bit 8 reads channel in progress, 0 left 1 right, resets to 1
// - control bit 7 reads 1 while transmit FIFO is not empty
// - control bit 6 reads 1 while receive FIFO is enabled and not full
// - control bit 5 enables the transmit DMA request
// - control bit 4 enables the receive DMA request
// - control bit 3 idles transmit: transmission paused, select line frozen only when receive is idle or off too
// - control bit 2 idles receive: reception paused, select line frozen only when transmit is idle or off too
// - mode bit 8: 0 drives bit clock and select, 1 takes them in
// - mode bits 7:6 pick none, receive, transmit or both directions
// - mode bit 5: 0 low level is left, 1 high level is left
// - mode bit 4: 0 standard framing, 1 MSB-justified framing
// - mode bit 3: 0 eight-bit samples, 1 sixteen-bit samples
// - mode bit 2: master clock is 256 or 384 times sample rate
// - mode bits 1:0: bit clock 16, 32 or 48 times sample rate
// - prescaler A bits 9:5 divide source clock by value plus one, internally
// - prescaler B bits 4:0 divide source clock by value plus one, for codec
// - FIFO control bits 15 and 14 pick processor or DMA access
// - FIFO control bits 13 and 12 enable transmit and receive FIFO
// - FIFO control bits 11:6 read transmit FIFO fill count
// - FIFO control bits 5:0 read receive FIFO fill count
// - both FIFOs are 16 bits wide and 32 entries deep
// - one entry port: writes feed transmit FIFO, reads drain receive FIFO
// - in DMA access the request follows that FIFO's ready flag
// - standard framing: select changes one bit before MSB, MSB first
// - justified framing: MSB appears in the period select changes
package sasp_pkg;
    localparam logic [31:0] ADDR_CTRL = 32'h5500_0000;
    localparam logic [31:0] ADDR_MODE = 32'h5500_0004;
    localparam logic [31:0] ADDR_PSR = 32'h5500_0008;
    localparam logic [31:0] ADDR_FCON = 32'h5500_000c;
    localparam logic [31:0] ADDR_ENTRY = 32'h5500_0010;
    // control fields
    localparam int CTL_CH = 8;
    localparam int CTL_TXRDY = 7;
    localparam int CTL_RXRDY = 6;
    localparam int CTL_TXDMA = 5;
    localparam int CTL_RXDMA = 4;
    localparam int CTL_TXIDLE = 3;
    localparam int CTL_RXIDLE = 2;
    localparam int CTL_PSEN = 1;
    localparam int CTL_EN = 0;
    // mode fields
    localparam int MOD_SLAVE = 8;
    localparam int MOD_TXDIR = 7;
    localparam int MOD_RXDIR = 6;
    localparam int MOD_LPOL = 5;
    localparam int MOD_FMT = 4;
    localparam int MOD_W16 = 3;
    localparam int MOD_384 = 2;
    localparam int MOD_BFS_HI = 1;
    localparam int MOD_BFS_LO = 0;
    // prescaler fields
    localparam int PSR_A_HI = 9;
    localparam int PSR_A_LO = 5;
    localparam int PSR_B_HI = 4;
    localparam int PSR_B_LO = 0;
    // fifo control fields
    localparam int FCON_TXDMA = 15;
    localparam int FCON_RXDMA = 14;
    localparam int FCON_TXEN = 13;
    localparam int FCON_RXEN = 12;
    localparam int FCON_CTRL_LO = 12;
    localparam int FCON_TXCNT_LO = 6;
    localparam int FCON_RXCNT_LO = 0;
    // reset values
    localparam logic [8:0] CTL_RST = 9'h100;
    localparam logic [8:0] MOD_RST = 9'h000;
    localparam logic [9:0] PSR_RST = 10'h000;
    localparam logic [3:0] FCON_RST = 4'h0;
    // fifo shape
    localparam int FIFO_W = 16;
    localparam int FIFO_D = 32;
    // half bit periods in master clock ticks, per master ratio and bit clock ratio
    localparam logic [7:0] HALF_256_16 = 8'h08;
    localparam logic [7:0] HALF_256_32 = 8'h04;
    localparam logic [7:0] HALF_256_48 = 8'h02;
    localparam logic [7:0] HALF_384_16 = 8'h0c;
    localparam logic [7:0] HALF_384_32 = 8'h06;
    localparam logic [7:0] HALF_384_48 = 8'h04;
    // bit clocks per channel slot
    localparam logic [4:0] BPC_16FS = 5'h08;
    localparam logic [4:0] BPC_32FS = 5'h10;
    localparam logic [4:0] BPC_48FS = 5'h18;
endpackage : sasp_pkg

// File: rtl/sasp_top.sv
`timescale 1ns/1ps
// sample buffer, one per direction
module sasp_fifo #(
    parameter int W = 16,
    parameter int D = 32,
    parameter int CW = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [CW-1:0] count
);
    localparam int AW = $clog2(D);
    if ((1 << AW) != D || CW <= AW)
        $error("fifo depth must be a power of two that the count can hold");
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } sasp_fifo_st_t;
    sasp_fifo_st_t s;
    sasp_fifo_st_t n;
    logic push;
    logic pop;

    // pointers wrap naturally since depth is a power of two
    always_comb
    begin
        n = s;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (clr)
        begin
            n.wp = '0;
            n.rp = '0;
            n.cnt = '0;
        end
        else
        begin
            if (push)
            begin
                n.mem[s.wp] = in_data;
                n.wp = s.wp + AW'(1);
            end
            if (pop)
                n.rp = s.rp + AW'(1);
            if (push && !pop)
                n.cnt = s.cnt + CW'(1);
            else if (!push && pop)
                n.cnt = s.cnt - CW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= n;
    end

    // a disabled fifo neither accepts nor offers data
    assign in_ready = !clr && (s.cnt != CW'(D));
    assign out_valid = !clr && (s.cnt != '0);
    assign out_data = s.mem[s.rp];
    assign count = s.cnt;
endmodule : sasp_fifo

module sasp_top #(
    parameter int FIFO_WIDTH = sasp_pkg::FIFO_W,
    parameter int FIFO_DEPTH = sasp_pkg::FIFO_D
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [31:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    input wire logic SERIAL_BIT_CLOCK_I,
    output logic SERIAL_BIT_CLOCK_O,
    output logic SERIAL_BIT_CLOCK_OE_N,
    input wire logic LEFT_RIGHT_SELECT_I,
    output logic LEFT_RIGHT_SELECT_O,
    output logic LEFT_RIGHT_SELECT_OE_N,
    input wire logic SERIAL_DATA_IN,
    output logic SERIAL_DATA_OUT,
    output logic CODEC_MASTER_CLOCK,
    output logic TX_DMA_REQ,
    output logic RX_DMA_REQ
);
    // count fields are six bits and the entry port is one halfword
    if (FIFO_WIDTH != 16 || FIFO_DEPTH > 32 || FIFO_DEPTH < 2)
        $error("fifo must be 16 bits wide and at most 32 deep");

    typedef struct packed {
        logic [5:0] ctl;
        logic ch;
        logic [8:0] mode;
        logic [9:0] psr;
        logic [3:0] fcon;
        logic [15:0] rdata;
        logic [4:0] pa;
        logic [4:0] pb;
        logic cmclk;
        logic [7:0] hdiv;
        logic sclk;
        logic [4:0] bcnt;
        logic sclk_q;
        logic [4:0] pos;
        logic [15:0] tx_sh;
        logic [15:0] rx_sh;
        logic rx_act;
        logic pend;
        logic sdo;
    } sasp_state_t;
    sasp_state_t s;
    sasp_state_t n;

    logic hit_ctl;
    logic hit_mode;
    logic hit_psr;
    logic hit_fcon;
    logic hit_entry;
    logic slave;
    logic tx_run;
    logic rx_run;
    logic mtick;
    logic rise;
    logic fall;
    logic bound;
    logic newch;
    logic tx_pop;
    logic rx_in_valid;
    logic tx_in_ready;
    logic rx_in_ready;
    logic tx_vld;
    logic rx_vld;
    logic [15:0] tx_data;
    logic [15:0] rx_data;
    logic [5:0] tx_cnt;
    logic [5:0] rx_cnt;
    logic [7:0] half;
    logic [4:0] bpc;
    logic [4:0] dly;
    logic [4:0] wid;
    logic wstart;
    logic [3:0] idx;

    assign hit_ctl = REG_ADDR == sasp_pkg::ADDR_CTRL;
    assign hit_mode = REG_ADDR == sasp_pkg::ADDR_MODE;
    assign hit_psr = REG_ADDR == sasp_pkg::ADDR_PSR;
    assign hit_fcon = REG_ADDR == sasp_pkg::ADDR_FCON;
    assign hit_entry = REG_ADDR == sasp_pkg::ADDR_ENTRY;

    // transmit buffer: processor or DMA writes, serialiser drains
    sasp_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH), .CW(6)) u_tx_fifo (
        .clk(CLK),
        .rst(RST),
        .clr(!s.fcon[sasp_pkg::FCON_TXEN - sasp_pkg::FCON_CTRL_LO]),
        .in_valid(REG_WR && hit_entry),
        .in_ready(tx_in_ready),
        .in_data(REG_WDATA),
        .out_valid(tx_vld),
        .out_ready(tx_pop),
        .out_data(tx_data),
        .count(tx_cnt)
    );

    // receive buffer: deserialiser fills, entry port reads drain
    sasp_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH), .CW(6)) u_rx_fifo (
        .clk(CLK),
        .rst(RST),
        .clr(!s.fcon[sasp_pkg::FCON_RXEN - sasp_pkg::FCON_CTRL_LO]),
        .in_valid(rx_in_valid),
        .in_ready(rx_in_ready),
        .in_data(s.rx_sh),
        .out_valid(rx_vld),
        .out_ready(REG_RD && hit_entry),
        .out_data(rx_data),
        .count(rx_cnt)
    );

    // register port, clock dividers, channel machine and shifters
    always_comb
    begin
        n = s;
        slave = s.mode[sasp_pkg::MOD_SLAVE];
        tx_run = s.ctl[sasp_pkg::CTL_EN] && s.mode[sasp_pkg::MOD_TXDIR] && !s.ctl[sasp_pkg::CTL_TXIDLE];
        rx_run = s.ctl[sasp_pkg::CTL_EN] && s.mode[sasp_pkg::MOD_RXDIR] && !s.ctl[sasp_pkg::CTL_RXIDLE];
        mtick = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        bound = 1'b0;
        newch = s.ch;
        tx_pop = 1'b0;
        rx_in_valid = 1'b0;
        dly = s.mode[sasp_pkg::MOD_FMT] ? 5'h00 : 5'h01;
        wid = s.mode[sasp_pkg::MOD_W16] ? 5'h10 : 5'h08;
        wstart = 1'b0;
        idx = 4'h0;
        // ratio table; code 11 of the bit clock field falls back to 32fs
        unique case ({s.mode[sasp_pkg::MOD_384], s.mode[sasp_pkg::MOD_BFS_HI:sasp_pkg::MOD_BFS_LO]})
            3'b000: half = sasp_pkg::HALF_256_16;
            3'b010: half = sasp_pkg::HALF_256_48;
            3'b100: half = sasp_pkg::HALF_384_16;
            3'b101: half = sasp_pkg::HALF_384_32;
            3'b110: half = sasp_pkg::HALF_384_48;
            3'b111: half = sasp_pkg::HALF_384_32;
            default: half = sasp_pkg::HALF_256_32;
        endcase
        unique case (s.mode[sasp_pkg::MOD_BFS_HI:sasp_pkg::MOD_BFS_LO])
            2'b00: bpc = sasp_pkg::BPC_16FS;
            2'b10: bpc = sasp_pkg::BPC_48FS;
            default: bpc = sasp_pkg::BPC_32FS;
        endcase

        // register writes; read-only fields are not stored
        if (REG_WR && hit_ctl)
            n.ctl = REG_WDATA[5:0];
        if (REG_WR && hit_mode)
            n.mode = REG_WDATA[8:0];
        if (REG_WR && hit_psr)
            n.psr = REG_WDATA[9:0];
        if (REG_WR && hit_fcon)
            n.fcon = REG_WDATA[15:12];

        // read data lands one cycle after the strobe
        if (REG_RD)
        begin
            if (hit_ctl)
                n.rdata = {7'h00, s.ch, tx_vld, rx_in_ready, s.ctl};
            else if (hit_mode)
                n.rdata = {7'h00, s.mode};
            else if (hit_psr)
                n.rdata = {6'h00, s.psr};
            else if (hit_fcon)
                n.rdata = {s.fcon, tx_cnt, rx_cnt};
            else if (hit_entry)
                n.rdata = rx_vld ? rx_data : 16'h0000;
            else
                n.rdata = 16'h0000;
        end

        // prescalers; a divide by one cannot make a codec clock, it then sits high
        if (s.ctl[sasp_pkg::CTL_PSEN])
        begin
            if (s.pa == s.psr[sasp_pkg::PSR_A_HI:sasp_pkg::PSR_A_LO])
            begin
                n.pa = 5'h00;
                mtick = 1'b1;
            end
            else
                n.pa = s.pa + 5'h01;
            if (s.pb == s.psr[sasp_pkg::PSR_B_HI:sasp_pkg::PSR_B_LO])
                n.pb = 5'h00;
            else
                n.pb = s.pb + 5'h01;
            n.cmclk = n.pb <= (s.psr[sasp_pkg::PSR_B_HI:sasp_pkg::PSR_B_LO] >> 1);
        end
        else
        begin
            n.pa = 5'h00;
            n.pb = 5'h00;
            n.cmclk = 1'b0;
        end

        // master: bit clock and select come from the internal master clock
        n.sclk_q = SERIAL_BIT_CLOCK_I;
        if (!slave)
        begin
            if (mtick && (tx_run || rx_run))
            begin
                if (s.hdiv >= half - 8'h01)
                begin
                    n.hdiv = 8'h00;
                    n.sclk = !s.sclk;
                    rise = !s.sclk;
                    fall = s.sclk;
                end
                else
                    n.hdiv = s.hdiv + 8'h01;
            end
            if (fall)
            begin
                if (s.bcnt >= bpc - 5'h01)
                begin
                    n.bcnt = 5'h00;
                    newch = !s.ch;
                    bound = 1'b1;
                end
                else
                    n.bcnt = s.bcnt + 5'h01;
            end
        end
        else if (tx_run || rx_run)
        begin
            // slave: select is taken on the leading edge of the bit clock
            rise = SERIAL_BIT_CLOCK_I && !s.sclk_q;
            fall = !SERIAL_BIT_CLOCK_I && s.sclk_q;
            if (rise)
            begin
                newch = LEFT_RIGHT_SELECT_I ^ s.mode[sasp_pkg::MOD_LPOL];
                bound = newch != s.ch;
            end
        end

        // channel boundary; in standard framing the old word still owes its last bit
        if (bound)
        begin
            n.ch = newch;
            n.pend = 1'b1;
        end

        // word start: hand over the finished word, load the next one
        wstart = (bound && dly == 5'h00) || (fall && !bound && s.pend);
        if (wstart)
        begin
            n.pend = 1'b0;
            n.pos = 5'h00;
            rx_in_valid = s.rx_act; // a full fifo drops the word, flag shows it
            n.rx_sh = 16'h0000;
            n.rx_act = rx_run;
            tx_pop = tx_run;
            n.tx_sh = (tx_run && tx_vld) ? tx_data : 16'h0000; // underrun sends silence
        end
        else if (fall && s.pos != 5'h1f)
            n.pos = s.pos + 5'h01;

        // bit position counts from the MSB slot, saturating past the word
        idx = 4'(wid - 5'h01 - n.pos);
        if (rise && n.rx_act && n.pos < wid)
            n.rx_sh[idx] = SERIAL_DATA_IN;
        if (fall || wstart)
            n.sdo = tx_run && n.pos < wid && n.tx_sh[idx];
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            s <= '0;
            s.ctl <= sasp_pkg::CTL_RST[5:0];
            s.ch <= sasp_pkg::CTL_RST[sasp_pkg::CTL_CH];
            s.mode <= sasp_pkg::MOD_RST;
            s.psr <= sasp_pkg::PSR_RST;
            s.fcon <= sasp_pkg::FCON_RST;
        end
        else
            s <= n;
    end

    // pins; enables are low while this end drives
    assign SERIAL_BIT_CLOCK_O = s.sclk;
    assign SERIAL_BIT_CLOCK_OE_N = s.mode[sasp_pkg::MOD_SLAVE];
    assign LEFT_RIGHT_SELECT_O = s.ch ^ s.mode[sasp_pkg::MOD_LPOL];
    assign LEFT_RIGHT_SELECT_OE_N = s.mode[sasp_pkg::MOD_SLAVE];
    assign SERIAL_DATA_OUT = s.sdo;
    assign CODEC_MASTER_CLOCK = s.cmclk;
    assign REG_RDATA = s.rdata;
    // requests follow the ready flags, not edges, so DMA may over-run by one
    assign TX_DMA_REQ = s.ctl[sasp_pkg::CTL_TXDMA] && s.fcon[sasp_pkg::FCON_TXDMA - sasp_pkg::FCON_CTRL_LO]
        && tx_vld;
    assign RX_DMA_REQ = s.ctl[sasp_pkg::CTL_RXDMA] && s.fcon[sasp_pkg::FCON_RXDMA - sasp_pkg::FCON_CTRL_LO]
        && rx_in_ready;

    // checks on the register view and the link
    property p_chan_rd;
        @(posedge CLK) disable iff (RST)
        REG_RD && hit_ctl |=> REG_RDATA[sasp_pkg::CTL_CH] == $past(s.ch);
    endproperty
    a_chan_rd: assert property (p_chan_rd) else $error("channel index misread");

    property p_txrdy_rd;
        @(posedge CLK) disable iff (RST)
        REG_RD && hit_ctl |=> REG_RDATA[sasp_pkg::CTL_TXRDY] == ($past(tx_cnt) != 6'h00);
    endproperty
    a_txrdy_rd: assert property (p_txrdy_rd) else $error("transmit ready flag wrong");

    property p_rxrdy_rd;
        @(posedge CLK) disable iff (RST)
        REG_RD && hit_ctl && s.fcon[0] |=> REG_RDATA[sasp_pkg::CTL_RXRDY] == ($past(rx_cnt) != 6'(FIFO_DEPTH));
    endproperty
    a_rxrdy_rd: assert property (p_rxrdy_rd) else $error("receive ready flag wrong");

    property p_txdreq_off;
        @(posedge CLK) disable iff (RST)
        !s.ctl[sasp_pkg::CTL_TXDMA] || tx_cnt == 6'h00 |-> !TX_DMA_REQ;
    endproperty
    a_txdreq_off: assert property (p_txdreq_off) else $error("transmit request while gated");

    property p_rxdreq_off;
        @(posedge CLK) disable iff (RST)
        !s.ctl[sasp_pkg::CTL_RXDMA] |-> !RX_DMA_REQ;
    endproperty
    a_rxdreq_off: assert property (p_rxdreq_off) else $error("receive request while gated");

    property p_idle_hold;
        @(posedge CLK) disable iff (RST)
        s.ctl[sasp_pkg::CTL_TXIDLE] && (s.ctl[sasp_pkg::CTL_RXIDLE] || !s.mode[sasp_pkg::MOD_RXDIR]) && !REG_WR
        |=> $stable(LEFT_RIGHT_SELECT_O);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("select moved while idle");

    property p_master_oe;
        @(posedge CLK) disable iff (RST)
        !s.mode[sasp_pkg::MOD_SLAVE] |-> !SERIAL_BIT_CLOCK_OE_N && !LEFT_RIGHT_SELECT_OE_N;
    endproperty
    a_master_oe: assert property (p_master_oe) else $error("master not driving clocks");

    property p_no_dir;
        @(posedge CLK) disable iff (RST)
        s.mode[7:6] == 2'b00 |-> !tx_pop;
    endproperty
    a_no_dir: assert property (p_no_dir) else $error("transmit pop with no direction");

    property p_fill_rd;
        @(posedge CLK) disable iff (RST)
        REG_RD && hit_fcon |=> REG_RDATA[11:6] == $past(tx_cnt) && REG_RDATA[5:0] == $past(rx_cnt);
    endproperty
    a_fill_rd: assert property (p_fill_rd) else $error("fill count misread");

    property p_entry_wr;
        @(posedge CLK) disable iff (RST)
        REG_WR && hit_entry && tx_in_ready && !(tx_pop && tx_vld) |=> tx_cnt == $past(tx_cnt) + 6'h01;
    endproperty
    a_entry_wr: assert property (p_entry_wr) else $error("entry write not stored");

    property p_bound_pos;
        @(posedge CLK) disable iff (RST)
        bound |=> s.ch == $past(newch) && (s.pend || s.pos == 5'h00);
    endproperty
    a_bound_pos: assert property (p_bound_pos) else $error("word boundary not taken");

    c_bound: cover property (@(posedge CLK) disable iff (RST) bound && !slave);
    c_rx_push: cover property (@(posedge CLK) disable iff (RST) rx_in_valid && rx_in_ready);
    c_tx_pop: cover property (@(posedge CLK) disable iff (RST) tx_pop && tx_vld);
    c_slave: cover property (@(posedge CLK) disable iff (RST) bound && slave);
endmodule : sasp_top

// File: testbench/sasp_codec_model.sv
`timescale 1ns/1ps
// codec stand-in: master mode only, standard framing, 16-bit slots
module sasp_codec_model #(
    parameter logic [15:0] RX_WORD = 16'ha5c3
) (
    input wire logic clk,
    input wire logic bclk,
    input wire logic lrs,
    input wire logic sdo,
    output logic sdi
);
    logic bclk_d = 1'b0;
    logic lr_rise = 1'b0;
    logic lr_fall = 1'b0;
    logic [15:0] sr = 16'h0000;
    logic [3:0] cnt = 4'hf;
    logic [15:0] cap[$];
    initial sdi = 1'b0;
    // sampled on falling clk so bit clock and select have both settled, no race
    always @(negedge clk)
    begin
        bclk_d <= bclk;
        // leading edge: bit of the period where select changed is the old lsb
        if (bclk && !bclk_d)
        begin
            if (lrs !== lr_rise)
                cap.push_back({sr[14:0], sdo});
            sr <= {sr[14:0], sdo};
            lr_rise <= lrs;
        end
        // trailing edge: msb goes out one period after select changes
        if (!bclk && bclk_d)
        begin
            if (lrs !== lr_fall)
            begin
                sdi <= RX_WORD[0];
                cnt <= 4'hf;
            end
            else
            begin
                sdi <= RX_WORD[cnt];
                cnt <= cnt - 4'h1;
            end
            lr_fall <= lrs;
        end
    end
endmodule : sasp_codec_model

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] addr = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic bclk_o, bclk_oe_n, lrs_o, lrs_oe_n, sdi, sdo, cclk, tx_req, rx_req;
    logic [15:0] v;
    logic lr_hold;
    logic bclk_i = 1'b0;
    logic lrs_i = 1'b0;
    int errors = 0;
    int samples_checked = 0;
    int k, n;
    sasp_top DUT (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .SERIAL_BIT_CLOCK_I(bclk_i), .SERIAL_BIT_CLOCK_O(bclk_o),
        .SERIAL_BIT_CLOCK_OE_N(bclk_oe_n), .LEFT_RIGHT_SELECT_I(lrs_i), .LEFT_RIGHT_SELECT_O(lrs_o),
        .LEFT_RIGHT_SELECT_OE_N(lrs_oe_n), .SERIAL_DATA_IN(sdi), .SERIAL_DATA_OUT(sdo),
        .CODEC_MASTER_CLOCK(cclk), .TX_DMA_REQ(tx_req), .RX_DMA_REQ(rx_req));
    sasp_codec_model codec (.clk(clk), .bclk(bclk_o), .lrs(lrs_o), .sdo(sdo), .sdi(sdi));
    initial
    begin
        forever #5 clk = ~clk;
    end
    function automatic logic [15:0] tx_val(input int i);
        tx_val = 16'h1234 + 16'(i) * 16'h0b17;
    endfunction : tx_val
    // strobes go up on a falling edge and drop on the next one
    task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [31:0] a, output logic [15:0] d);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask : rd_reg
    // one slave bit clock pulse with the select level set together with its rising edge
    task automatic slave_bit(input logic sel);
        @(negedge clk);
        lrs_i = sel;
        bclk_i = 1'b1;
        @(negedge clk);
        bclk_i = 1'b0;
    endtask : slave_bit
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : chk
    task automatic rd_chk(input string name, input logic [31:0] a, input logic [15:0] mask, input logic [15:0] exp);
        logic [15:0] d;
        rd_reg(a, d);
        chk(name, exp, d & mask);
    endtask : rd_chk
    task automatic results;
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        // reset values, unmapped place reads zero
        rd_chk("control", sasp_pkg::ADDR_CTRL, 16'hffff, 16'h0100);
        rd_chk("mode", sasp_pkg::ADDR_MODE, 16'hffff, 16'h0000);
        rd_chk("prescaler", sasp_pkg::ADDR_PSR, 16'hffff, 16'h0000);
        rd_chk("fifo_control", sasp_pkg::ADDR_FCON, 16'hffff, 16'h0000);
        rd_chk("unmapped", 32'h5500_0020, 16'hffff, 16'h0000);
        chk("clock_oe_n", 16'h0000, {15'h0000, bclk_oe_n});
        wr_reg(sasp_pkg::ADDR_MODE, 16'h0100);
        repeat (2) @(negedge clk);
        chk("clock_oe_n", 16'h0001, {15'h0000, bclk_oe_n});
        chk("select_oe_n", 16'h0001, {15'h0000, lrs_oe_n});
        // fill the transmit buffer past full: the extra write is dropped
        wr_reg(sasp_pkg::ADDR_FCON, 16'hf000);
        for (int i = 0; i < 33; i++)
            wr_reg(sasp_pkg::ADDR_ENTRY, tx_val(i));
        rd_chk("fifo_control", sasp_pkg::ADDR_FCON, 16'hffff, 16'hf800);
        rd_chk("ready_flags", sasp_pkg::ADDR_CTRL, 16'h00c0, 16'h00c0);
        // requests follow ready flags only when gated on in both registers
        wr_reg(sasp_pkg::ADDR_CTRL, 16'h0030);
        chk("tx_req", 16'h0001, {15'h0000, tx_req});
        chk("rx_req", 16'h0001, {15'h0000, rx_req});
        wr_reg(sasp_pkg::ADDR_FCON, 16'h3000);
        chk("tx_req", 16'h0000, {15'h0000, tx_req});
        chk("rx_req", 16'h0000, {15'h0000, rx_req});
        // master, both directions, 16-bit, 256fs, 32fs, codec divide by four
        wr_reg(sasp_pkg::ADDR_PSR, 16'h0003);
        wr_reg(sasp_pkg::ADDR_MODE, 16'h00c9);
        rd_chk("mode", sasp_pkg::ADDR_MODE, 16'hffff, 16'h00c9);
        wr_reg(sasp_pkg::ADDR_CTRL, 16'h0003);
        repeat (10) @(negedge clk);
        n = 0;
        v[0] = cclk;
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk);
            if (cclk !== v[0])
                n++;
            v[0] = cclk;
        end
        chk("codec_clock_toggles", 16'd20, 16'(n));
        // bounded wait for captured words at the codec
        k = 0;
        while (codec.cap.size() < 20 && k < 20000)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 20000)
        begin
            $display("Error capture expected 20 words seen %0d", codec.cap.size());
            errors++;
        end
        k = -1;
        for (int i = 0; i < 6; i++)
            if (k < 0 && codec.cap[i] === tx_val(0))
                k = i;
        chk("first_word_found", 16'h0001, {15'h0000, k >= 0});
        if (k >= 0)
            for (int i = 1; i < 4; i++)
                chk("serial_word", tx_val(i), codec.cap[k + i]);
        // received words come back through the entry port
        for (int i = 0; i < 3; i++)
            rd_reg(sasp_pkg::ADDR_ENTRY, v);
        chk("rx_word", 16'ha5c3, v);
        // idle freezes the select line
        wr_reg(sasp_pkg::ADDR_CTRL, 16'h000f);
        repeat (4) @(negedge clk);
        lr_hold = lrs_o;
        n = 0;
        repeat (300)
        begin
            @(negedge clk);
            if (lrs_o !== lr_hold)
                n++;
        end
        chk("select_idle", 16'h0000, 16'(n));
        // slave with high marking left: select taken at the rising bit clock
        wr_reg(sasp_pkg::ADDR_MODE, 16'h01e9);
        wr_reg(sasp_pkg::ADDR_CTRL, 16'h0003);
        slave_bit(1'b1);
        rd_chk("slave_channel", sasp_pkg::ADDR_CTRL, 16'h0100, 16'h0000);
        slave_bit(1'b0);
        rd_chk("slave_channel", sasp_pkg::ADDR_CTRL, 16'h0100, 16'h0100);
        results();
    end
endmodule : testbench
